/* File: rtl/bcm_boot_mode11.sv */
// Mode-11 boot defaults loader and timed power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module bcm_boot_mode11 import bcm_pkg::*; #(
  parameter int SLOT_CYCLES = BCM_SLOT_CYCLES,
  parameter int NUM_SLOTS = BCM_NUM_SLOTS,
  parameter int NUM_BUCK = BCM_NUM_BUCK,
  parameter int NUM_REG = BCM_NUM_REG,
  parameter int NUM_PIN = BCM_NUM_PIN
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Sequence control
  input wire logic i_start,
  // Runtime writes, taken only in ACTIVE
  input wire logic i_rt_wr,
  input wire logic [5:0] i_rt_buck_enable,
  input wire logic [3:0] i_rt_reg_enable,
  input wire logic i_rt_limit_switch,
  // Sequencer status
  output logic o_active,
  output logic [3:0] o_slot,
  // Supply enables
  output logic [5:0] o_buck_enable_bit,
  output logic [3:0] o_reg_enable,
  output logic o_limit_switch_close,
  // Supply slots and voltage codes
  output logic [23:0] o_buck_startup_slot,
  output logic [15:0] o_reg_startup_slot,
  output logic [41:0] o_buck_voltage_code,
  output logic [19:0] o_reg_voltage_code,
  // General system settings
  output logic o_power_on_pin_polarity,
  output logic o_usb_slave_high_current_sel,
  output logic [1:0] o_watchdog_mode_field,
  output logic o_ctrl_if_three_wire_sel,
  output logic o_ctrl_if_four_wire_sel,
  output logic o_ctrl_if_serial_cfg,
  output logic o_slow_osc_enable,
  output logic o_rtc_tick_enable,
  output logic o_rtc_clock_source_sel,
  output logic o_reg1_pin_control_mode,
  output logic o_reg1_pin_enable,
  // Pin configuration
  output logic [51:0] o_pin_function_sel,
  output logic [12:0] o_pin_direction,
  output logic [12:0] o_pin_polarity_or_drive_cfg,
  output logic [12:0] o_pin_pullup_en,
  output logic [12:0] o_pin_pulldown_en,
  output logic [12:0] o_pin_debounce_en,
  output logic [1:0] o_debounce_time_sel,
  output logic [6:0] o_wake_debounce_ms,
  output logic [12:0] o_pin_active_low
);
  typedef struct packed {
    bcm_state_e state;
    logic [5:0] buck_en;
    logic [3:0] reg_en;
    logic limsw;
  } bcm_top_s;
  bcm_top_s st, next_st;

  bcm_slot_if slot_if ();

  // Slot interval timer
  bcm_slot_timer #(
    .SLOT_CYCLES(SLOT_CYCLES),
    .NUM_SLOTS(NUM_SLOTS)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .slot_if(slot_if.timer)
  );

  // Does a slot code fire at this slot, or on entry to ACTIVE
  function automatic logic slot_hit(input logic [3:0] code, input logic [3:0] slot,
                                    input logic entering);
    logic hit;
    hit = 1'b0;
    if (code == BCM_SLOT_ACTIVE) begin
      hit = entering;
    end else if (code != BCM_SLOT_OFF) begin
      hit = (code == slot);
    end
    return hit;
  endfunction : slot_hit

  // Polarity meaning per pin function; some inputs invert the sense
  // Outputs have no active sense: their cfg bit picks the drive type instead
  function automatic logic pin_low(input logic [3:0] fn, input logic cfg, input logic dir,
                                   input int idx);
    logic inv;
    inv = 1'b0;
    if ((idx == 4 && fn == 4'h1) || (idx == 11 && fn == 4'h2)) begin
      inv = 1'b1;
    end
    return dir ? (inv ? cfg : !cfg) : 1'b0;
  endfunction : pin_low

  logic entering;
  logic [5:0] buck_hit;
  logic [3:0] reg_hit;

  assign slot_if.run = (st.state == BCM_ST_SEQ);
  assign entering = slot_if.run && slot_if.done;

  // Per-supply slot match, evaluated on each slot tick
  for (genvar g = 0; g < NUM_BUCK; g++) begin : g_buck
    assign buck_hit[g] = slot_hit(BCM_RST_BUCK_SLOT[4*g +: 4], slot_if.slot, entering)
                         && (slot_if.tick || entering);
  end
  for (genvar g = 0; g < NUM_REG; g++) begin : g_reg
    assign reg_hit[g] = slot_hit(BCM_RST_REG_SLOT[4*g +: 4], slot_if.slot, entering)
                        && (slot_if.tick || entering);
  end

  // Sequencer state and supply enables
  always_comb begin
    next_st = st;
    case (st.state)
      BCM_ST_LOAD: begin
        if (i_start) begin
          next_st.state = BCM_ST_SEQ;
        end
      end
      BCM_ST_SEQ: begin
        next_st.buck_en = st.buck_en | buck_hit;
        next_st.reg_en = st.reg_en | reg_hit;
        next_st.limsw = 1'b0; // Never closed while starting
        if (slot_if.done) begin
          next_st.state = BCM_ST_ACTIVE;
        end
      end
      BCM_ST_ACTIVE: begin
        if (i_rt_wr) begin
          next_st.buck_en = i_rt_buck_enable;
          next_st.reg_en = i_rt_reg_enable;
          next_st.limsw = i_rt_limit_switch;
        end
      end
      default: begin
        next_st.state = BCM_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '{state: BCM_ST_LOAD, buck_en: 6'h00, reg_en: 4'h0, limsw: BCM_RST_LIMSW};
    end else begin
      st <= next_st;
    end
  end

  // Status and enables; regulator 1 forced on by pin mode
  assign o_active = (st.state == BCM_ST_ACTIVE);
  assign o_slot = slot_if.slot;
  assign o_buck_enable_bit = st.buck_en;
  assign o_reg_enable = {st.reg_en[3:1], st.reg_en[0] | BCM_RST_R1_MODE};
  assign o_limit_switch_close = st.limsw;

  // Preset supply settings
  assign o_buck_startup_slot = BCM_RST_BUCK_SLOT;
  assign o_reg_startup_slot = BCM_RST_REG_SLOT;
  assign o_buck_voltage_code = BCM_RST_BUCK_V;
  assign o_reg_voltage_code = BCM_RST_REG_V;

  // Preset system settings
  assign o_power_on_pin_polarity = BCM_RST_POWER_ON_PIN_POLARITY;
  assign o_usb_slave_high_current_sel = BCM_RST_USB_HI;
  assign o_watchdog_mode_field = BCM_RST_WDOG;
  assign o_ctrl_if_three_wire_sel = BCM_RST_IF3;
  assign o_ctrl_if_four_wire_sel = BCM_RST_IF4;
  assign o_ctrl_if_serial_cfg = BCM_RST_IFCFG;
  assign o_slow_osc_enable = BCM_RST_OSC;
  assign o_rtc_tick_enable = BCM_RST_TICK;
  assign o_rtc_clock_source_sel = BCM_RST_CLKSRC;
  assign o_reg1_pin_control_mode = BCM_RST_R1_MODE;
  assign o_reg1_pin_enable = BCM_RST_R1_PINEN;

  // Preset pin settings
  assign o_pin_function_sel = BCM_RST_PIN_FN;
  assign o_pin_direction = BCM_RST_PIN_DIR;
  assign o_pin_polarity_or_drive_cfg = BCM_RST_PIN_CFG;
  assign o_pin_pullup_en = BCM_RST_PIN_PU;
  assign o_pin_pulldown_en = BCM_RST_PIN_PD;
  assign o_pin_debounce_en = BCM_RST_PIN_DB;
  assign o_debounce_time_sel = BCM_RST_DBTIME;
  assign o_wake_debounce_ms = 7'(BCM_DB_BASE_MS) + {5'h00, BCM_RST_DBTIME};

  // Effective active-low sense per pin; pins 4 and 11 follow their polarity bit directly
  for (genvar g = 0; g < NUM_PIN; g++) begin : g_pin
    assign o_pin_active_low[g] = pin_low(BCM_RST_PIN_FN[4*g +: 4], BCM_RST_PIN_CFG[g],
                                         BCM_RST_PIN_DIR[g], g);
  end
endmodule : bcm_boot_mode11
`default_nettype wire

/* File: rtl/bcm_pkg.sv */
// Package of preset defaults and timing for the mode-11 boot configuration loader
package bcm_pkg;
  // Timing
  localparam int BCM_CLK_MHZ = 100;
  localparam int BCM_SLOT_TIME_US = 1280;
  localparam int BCM_SLOT_CYCLES = BCM_SLOT_TIME_US * BCM_CLK_MHZ;
  localparam int BCM_DB_BASE_MS = 40;
  localparam int BCM_NUM_SLOTS = 14;
  localparam int BCM_NUM_BUCK = 6;
  localparam int BCM_NUM_REG = 4;
  localparam int BCM_NUM_PIN = 13;
  // Slot code meanings
  localparam logic [3:0] BCM_SLOT_OFF = 4'h0;
  localparam logic [3:0] BCM_SLOT_ACTIVE = 4'hF;
  // General system defaults
  localparam logic BCM_RST_POWER_ON_PIN_POLARITY = 1'b1;
  localparam logic BCM_RST_USB_HI = 1'b1;
  localparam logic [1:0] BCM_RST_WDOG = 2'h0;
  localparam logic BCM_RST_IF3 = 1'b0;
  localparam logic BCM_RST_IF4 = 1'b0;
  localparam logic BCM_RST_IFCFG = 1'b0;
  localparam logic BCM_RST_OSC = 1'b1;
  localparam logic BCM_RST_TICK = 1'b1;
  localparam logic BCM_RST_CLKSRC = 1'b0;
  localparam logic BCM_RST_R1_MODE = 1'b1;
  localparam logic BCM_RST_R1_PINEN = 1'b0;
  localparam logic BCM_RST_LIMSW = 1'b0;
  // Start-up slots, index 0 is converter/regulator 1
  localparam logic [23:0] BCM_RST_BUCK_SLOT = 24'h10_3002;
  localparam logic [15:0] BCM_RST_REG_SLOT = 16'h0000;
  // Voltage codes, 7 bits per converter, converter 1 in the low bits
  localparam logic [41:0] BCM_RST_BUCK_V = {7'h26, 7'h00, 7'h06, 7'h0E, 7'h00, 7'h62};
  localparam logic [19:0] BCM_RST_REG_V = {5'h1F, 5'h1F, 5'h1A, 5'h02};
  // Pin function codes, pin 0 in the low nibble
  localparam logic [51:0] BCM_RST_PIN_FN = {4'h3, 4'h2, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0,
                                            4'h0, 4'h1, 4'h0, 4'h3, 4'h1, 4'h0};
  localparam logic [12:0] BCM_RST_PIN_DIR = 13'h0BFB;
  localparam logic [12:0] BCM_RST_PIN_CFG = 13'h0FFD;
  localparam logic [12:0] BCM_RST_PIN_PU = 13'h0010;
  localparam logic [12:0] BCM_RST_PIN_PD = 13'h0000;
  localparam logic [12:0] BCM_RST_PIN_DB = 13'h1FFF;
  localparam logic [1:0] BCM_RST_DBTIME = 2'h0;
  // Sequencer states
  typedef enum logic [1:0] {
    BCM_ST_LOAD = 2'b00,
    BCM_ST_SEQ = 2'b01,
    BCM_ST_ACTIVE = 2'b10
  } bcm_state_e;
endpackage : bcm_pkg

/* File: rtl/bcm_slot_if.sv */
// Interface carrying slot progress from the timer to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface bcm_slot_if;
  logic run;
  logic tick;
  logic [3:0] slot;
  logic done;
  modport timer (input run, output tick, output slot, output done);
  modport seq (output run, input tick, input slot, input done);
endinterface : bcm_slot_if
`default_nettype wire

/* File: rtl/bcm_slot_timer.sv */
// Slot timer: counts start-up slots 1..N at a fixed interval
`timescale 1ns/1ps
`default_nettype none
module bcm_slot_timer import bcm_pkg::*; #(
  parameter int SLOT_CYCLES = BCM_SLOT_CYCLES,
  parameter int NUM_SLOTS = BCM_NUM_SLOTS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Slot progress
  bcm_slot_if.timer slot_if
);
  typedef struct packed {
    logic [17:0] cnt;
    logic [3:0] slot;
    logic tick;
    logic done;
  } bcm_tmr_s;
  bcm_tmr_s st, next_st;

  // Interval counter; each wrap advances one slot
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (slot_if.run && !st.done) begin
      if (st.cnt == 18'(SLOT_CYCLES - 1)) begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
        next_st.slot = st.slot + 4'h1;
        if (st.slot == 4'(NUM_SLOTS - 1)) begin
          next_st.done = 1'b1; // Last slot reached
        end
      end else begin
        next_st.cnt = st.cnt + 18'h0_0001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign slot_if.tick = st.tick;
  assign slot_if.slot = st.slot;
  assign slot_if.done = st.done;
endmodule : bcm_slot_timer
`default_nettype wire

/* File: dv/bcm_boot_mode11_properties.sv */
// Checker of sequencing and default relations at the mode-11 loader ports
`timescale 1ns/1ps
`default_nettype none
module bcm_boot_mode11_properties #(
  parameter int SLOT_CYCLES = 4,
  parameter int NUM_SLOTS = 3
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Runtime writes
  input wire logic i_rt_wr,
  input wire logic [5:0] i_rt_buck_enable,
  input wire logic i_rt_limit_switch,
  // Watched outputs
  input wire logic o_active,
  input wire logic [3:0] o_slot,
  input wire logic [5:0] o_buck_enable_bit,
  input wire logic [3:0] o_reg_enable,
  input wire logic o_limit_switch_close,
  input wire logic [23:0] o_buck_startup_slot,
  input wire logic [12:0] o_pin_polarity_or_drive_cfg
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic [31:0] gap;
  logic [3:0] prev_slot;
  // Edges since the slot count last moved; a counter avoids a long repetition
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap <= '0;
      prev_slot <= '0;
    end else begin
      prev_slot <= o_slot;
      gap <= (o_slot != prev_slot) ? '0 : gap + 32'd1;
    end
  end
  // Slot count has just arrived at a value
  sequence s_enter(int k);
    o_slot == k && $changed(o_slot);
  endsequence
  a_reg1_on: assert property (o_reg_enable[0]) else $error("regulator 1 off");
  a_limit_open: assert property (!o_active |-> !o_limit_switch_close)
    else $error("limit switch closed before active");
  a_slot_gap: assert property ((prev_slot != 4'h0 && o_slot == prev_slot + 4'h1)
    |-> gap == SLOT_CYCLES - 1) else $error("slot interval wrong");
  a_buck6_first: assert property (s_enter(1) |-> ##[0:2] o_buck_enable_bit[5])
    else $error("buck 6 not on in slot 1");
  a_buck1_second: assert property (s_enter(2) |-> ##[0:2] o_buck_enable_bit[0])
    else $error("buck 1 not on in slot 2");
  a_buck4_third: assert property (s_enter(3) |-> ##[0:2] o_buck_enable_bit[3])
    else $error("buck 4 not on in slot 3");
  a_slot1_order: assert property (!o_active && o_slot == 4'h1 |-> !o_buck_enable_bit[0])
    else $error("buck 1 on too early");
  a_unslotted_off: assert property (!o_active |-> o_buck_enable_bit[4] == 1'b0
    && o_buck_enable_bit[2:1] == 2'b00) else $error("unslotted buck on");
  a_active_end: assert property (s_enter(NUM_SLOTS) |-> ##[1:3] o_active)
    else $error("active not reached after last slot");
  a_rt_write: assert property (o_active && i_rt_wr |=> o_buck_enable_bit ==
    $past(i_rt_buck_enable) && o_limit_switch_close == $past(i_rt_limit_switch))
    else $error("runtime write not applied");
  a_slot_codes: assert property (o_buck_startup_slot == 24'h10_3002)
    else $error("buck slot codes wrong");
  a_pin_cfg: assert property (o_pin_polarity_or_drive_cfg == 13'h0FFD)
    else $error("pin polarity defaults wrong");
endmodule : bcm_boot_mode11_properties
bind bcm_boot_mode11 bcm_boot_mode11_properties #(.SLOT_CYCLES(SLOT_CYCLES),
  .NUM_SLOTS(NUM_SLOTS)) chk_u (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_rt_wr(i_rt_wr),
  .i_rt_buck_enable(i_rt_buck_enable), .i_rt_limit_switch(i_rt_limit_switch),
  .o_active(o_active), .o_slot(o_slot), .o_buck_enable_bit(o_buck_enable_bit),
  .o_reg_enable(o_reg_enable), .o_limit_switch_close(o_limit_switch_close),
  .o_buck_startup_slot(o_buck_startup_slot),
  .o_pin_polarity_or_drive_cfg(o_pin_polarity_or_drive_cfg));
`default_nettype wire

/* File: dv/bcm_boot_mode11_bench.sv */
// Self-checking bench for the mode-11 boot defaults loader
`timescale 1ns/1ps
`default_nettype none
module boot_config_mode11_defaults_bench;
  localparam int SLOT = 4;
  // Stimulus and observed ports
  logic i_core_clk, i_rstn, i_start, i_rt_wr, i_rt_limit_switch;
  logic [5:0] i_rt_buck_enable;
  logic [3:0] i_rt_reg_enable;
  wire o_active, o_lim;
  wire [3:0] o_slot, o_reg_en;
  wire [5:0] o_buck_en;
  wire [23:0] o_bslot;
  wire [15:0] o_rslot;
  wire [41:0] o_bv;
  wire [19:0] o_rv;
  wire [1:0] o_wd, o_dbt;
  wire [6:0] o_wdb;
  wire [51:0] o_fn;
  wire [12:0] o_dir, o_cfg, o_pu, o_pd, o_db, o_al;
  wire [9:0] gen;
  int failures, tests_run;
  time t0;
  // Rows: slot awaited, buck and regulator enables expected two edges later
  logic [13:0] rows [3] = '{{4'h1, 6'h20, 4'h1}, {4'h2, 6'h21, 4'h1}, {4'h3, 6'h29, 4'h1}};
  bcm_boot_mode11 #(.SLOT_CYCLES(SLOT), .NUM_SLOTS(3)) dut_u (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start), .i_rt_wr(i_rt_wr),
    .i_rt_buck_enable(i_rt_buck_enable), .i_rt_reg_enable(i_rt_reg_enable),
    .i_rt_limit_switch(i_rt_limit_switch), .o_active(o_active), .o_slot(o_slot),
    .o_buck_enable_bit(o_buck_en), .o_reg_enable(o_reg_en), .o_limit_switch_close(o_lim),
    .o_buck_startup_slot(o_bslot), .o_reg_startup_slot(o_rslot), .o_buck_voltage_code(o_bv),
    .o_reg_voltage_code(o_rv), .o_power_on_pin_polarity(gen[0]),
    .o_usb_slave_high_current_sel(gen[1]), .o_watchdog_mode_field(o_wd),
    .o_ctrl_if_three_wire_sel(gen[2]), .o_ctrl_if_four_wire_sel(gen[3]),
    .o_ctrl_if_serial_cfg(gen[4]), .o_slow_osc_enable(gen[5]), .o_rtc_tick_enable(gen[6]),
    .o_rtc_clock_source_sel(gen[7]), .o_reg1_pin_control_mode(gen[8]),
    .o_reg1_pin_enable(gen[9]), .o_pin_function_sel(o_fn), .o_pin_direction(o_dir),
    .o_pin_polarity_or_drive_cfg(o_cfg), .o_pin_pullup_en(o_pu), .o_pin_pulldown_en(o_pd),
    .o_pin_debounce_en(o_db), .o_debounce_time_sel(o_dbt), .o_wake_debounce_ms(o_wdb),
    .o_pin_active_low(o_al));
  // Free-running core clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  // Bounded poll, so a stuck timer cannot hang the run
  task automatic wait_slot(input logic [3:0] s);
    for (int n = 0; n < 50 && o_slot !== s; n++) step(1);
  endtask : wait_slot
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  // Watchdog sized well above the few dozen cycles the tests need
  initial begin
    #20000;
    failures++;
    summarize();
  end
  initial begin
    {i_rstn, i_start, i_rt_wr, i_rt_limit_switch, i_rt_buck_enable, i_rt_reg_enable} = '0;
    step(10);
    i_rstn = 1'b1;
    check(o_buck_en, 6'h00);
    check(o_reg_en, 4'h1);
    check(gen[1:0], 2'h3);
    check(o_wd, 2'h0);
    check(gen[4:2], 3'h0);
    check(gen[7:5], 3'h3);
    check(gen[9:8], 2'h1);
    check(o_bslot, 24'h10_3002);
    check(o_rslot, 16'h0000);
    check({o_bv[41:35], o_bv[27:14], o_bv[6:0]}, {7'h26, 7'h06, 7'h0E, 7'h62});
    check(o_rv, {5'h1F, 5'h1F, 5'h1A, 5'h02});
    check(o_fn, 52'h3_2300_0001_0310);
    check(o_dir, 13'h0BFB);
    check({o_pu, o_pd}, {13'h0010, 13'h0000});
    check(o_cfg, 13'h0FFD);
    check(o_al, 13'h0812);
    check({o_db, o_dbt, o_wdb}, {13'h1FFF, 2'h0, 7'h28});
    $display("test defaults done");
    // Runtime write while loading must be ignored
    {i_rt_buck_enable, i_rt_reg_enable, i_rt_limit_switch} = '1;
    i_rt_wr = 1'b1;
    step(1);
    i_rt_wr = 1'b0;
    i_start = 1'b1;
    step(1);
    i_start = 1'b0;
    for (int r = 0; r < 3; r++) begin
      wait_slot(rows[r][13:10]);
      check(o_slot, rows[r][13:10]);
      if (r > 0) check($time - t0, SLOT * 10);
      t0 = $time;
      i_rt_wr = 1'b1;
      step(1);
      i_rt_wr = 1'b0;
      step(1);
      check(o_buck_en, rows[r][9:4]);
      check({o_reg_en, o_lim}, {rows[r][3:0], 1'b0});
    end
    for (int n = 0; n < 50 && o_active !== 1'b1; n++) step(1);
    check({o_active, o_lim, o_buck_en}, {2'b10, 6'h29});
    $display("test sequence done");
    // Start while active is refused, then a runtime write takes over
    i_start = 1'b1;
    step(1);
    i_start = 1'b0;
    {i_rt_buck_enable, i_rt_reg_enable, i_rt_limit_switch} = {6'h16, 4'h6, 1'b1};
    i_rt_wr = 1'b1;
    step(1);
    i_rt_wr = 1'b0;
    step(1);
    check({o_active, o_buck_en, o_reg_en, o_lim}, {1'b1, 6'h16, 4'h7, 1'b1});
    $display("test runtime done");
    // Reset in mid-run returns to load defaults
    i_rstn = 1'b0;
    step(1);
    check({o_active, o_buck_en, o_reg_en, o_lim}, {1'b0, 6'h00, 4'h1, 1'b0});
    i_rstn = 1'b1;
    step(2);
    check({o_active, o_slot, o_buck_en, o_reg_en}, {1'b0, 4'h0, 6'h00, 4'h1});
    $display("test reset done");
    summarize();
  end
endmodule : boot_config_mode11_defaults_bench
`default_nettype wire
